//--- pkg/typeb_defs.vh
// Purpose: shared constants for the type b attach/halt command handler
// Assumes: included by bare name from every design file that needs it
// Notes: offsets are apb byte addresses, one 32-bit word per register
`ifndef TYPEB_DEFS_VH
`define TYPEB_DEFS_VH

// apb register map
`define REG_CTRL 8'h00
`define REG_PUPI 8'h04
`define REG_STATUS 8'h08
// ctrl fields
`define CTRL_ENABLE_BIT 0
`define CTRL_WAKE_BIT 1
`define CTRL_RESET 32'h0000_0001
// default identifier, arbitrary value
`define PUPI_DEFAULT 32'h1234_5678
// status field positions
`define ST_STATE_LSB 0
`define ST_ATTACH_BIT 2
`define ST_HALT_BIT 3
`define ST_FSC_LSB 8
`define ST_RATE_LSB 12
`define ST_DISCARD_LSB 16

// tag states
`define TAG_READY 2'h0
`define TAG_ACTIVE 2'h1
`define TAG_HALT 2'h2

// command codes and frame lengths
`define CMD_ATTACH 8'h1D
`define CMD_HALT 8'h50
`define LEN_ATTACH 4'hB
`define LEN_HALT 4'h7
`define FRAME_MAX 11

// attach parameter checks
`define RATE_106 2'h0
`define RATE_212 2'h1
`define FSC_64 4'h5
`define FSC_96 4'h6
`define FSC_128 4'h7
`define FSC_256 4'h8
`define PARAM3_EXPECT 8'h01
`define PROTO_TYPE 4'h1
`define CID_NONE 4'h0

// responses
`define RESP_ATTACH 8'h10
`define MAX_BUF_LEN_CODE 4'h1
`define RESP_HALT 8'h00

// crc_b constants
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hF0B8

`endif

//--- src/attach_param_check.v
// Purpose: checks the attach command parameters two to four
// Assumes: parameter one is fully tolerated and not looked at here
// Notes: combinational; ok high means the tag may answer
`timescale 1ns/100ps
`default_nettype none
`include "typeb_defs.vh"

module attach_param_check (
  input wire [7:0] param2,
  input wire [7:0] param3,
  input wire [7:0] param4,
  output wire ok
);

  // supported rate code: 106 or 212 kbps only
  function rate_supported;
    input [1:0] code;
    begin
      rate_supported = (code == `RATE_106) || (code == `RATE_212);
    end
  endfunction

  wire rate_ok;
  wire fsc_ok;
  wire p3_ok;
  wire p4_ok;

  // both directions must be supported and equal
  assign rate_ok = rate_supported(param2[7:6]) && rate_supported(param2[5:4])
                   && (param2[7:6] == param2[5:4]);
  // reader frame size limited to 64..256 bytes
  assign fsc_ok = (param2[3:0] == `FSC_256) || (param2[3:0] == `FSC_128) ||
                  (param2[3:0] == `FSC_96) || (param2[3:0] == `FSC_64);
  // protocol nibble must echo what the tag advertised, upper nibble zero
  assign p3_ok = (param3 == `PARAM3_EXPECT) && (param3[3:0] == `PROTO_TYPE);
  // upper nibble ignored, no card identifier supported
  assign p4_ok = (param4[3:0] == `CID_NONE);

  assign ok = rate_ok && fsc_ok && p3_ok && p4_ok;

endmodule // attach_param_check

`default_nettype wire

//--- src/crc_b_step.v
// Purpose: one byte step of the crc_b register, lsb first
// Assumes: reflected polynomial, caller holds the register
// Notes: purely combinational, used for receive and transmit
`timescale 1ns/100ps
`default_nettype none
`include "typeb_defs.vh"

module crc_b_step (
  input wire [15:0] crc_in,
  input wire [7:0] data_in,
  output wire [15:0] crc_out
);

  wire [15:0] stage [0:8];

  assign stage[0] = crc_in;

  // eight bit-serial shifts unrolled by generate
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      wire fb;
      assign fb = stage[i][0] ^ data_in[i];
      assign stage[i + 1] = (stage[i] >> 1) ^ (fb ? `CRC_POLY : 16'h0000);
    end
  endgenerate

  assign crc_out = stage[8];

endmodule // crc_b_step

`default_nettype wire

//--- src/typeb_attach_halt_handler.v
// Purpose: type b attach and halt command handling behind an apb slave
// Assumes: received bytes arrive already decoded on pclk, one frame ends
//   with an rx_end pulse at least one cycle after its last byte
// Notes: answers leave on a valid/ready byte stream, crc_b appended
`timescale 1ns/100ps
`default_nettype none
`include "typeb_defs.vh"

module typeb_attach_halt_handler #(
  parameter [31:0] PUPI_RESET = `PUPI_DEFAULT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_end,
  input wire tx_ready,
  output wire tx_valid,
  output wire [7:0] tx_data,
  output wire tx_last,
  output wire [1:0] tag_state,
  output wire app_enable
);

  localparam TX_IDLE = 2'h0;
  localparam TX_CODE = 2'h1;
  localparam TX_CRC_LO = 2'h2;
  localparam TX_CRC_HI = 2'h3;

  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg enable_q;
  reg [31:0] pupi_q;
  reg [1:0] state_q;
  reg attach_seen_q;
  reg halt_seen_q;
  reg [3:0] fsc_q;
  reg [1:0] rate_q;
  reg [7:0] discard_q;
  reg [7:0] frame_q [0:`FRAME_MAX-1];
  reg [3:0] cnt_q;
  reg [15:0] crc_q;
  reg [1:0] tx_st_q;
  reg [7:0] resp_q;
  reg tx_valid_q;
  reg [7:0] tx_data_q;
  reg tx_last_q;
  reg app_enable_q;
  integer k;

  wire [15:0] rx_crc_next;
  wire [15:0] tx_crc_raw;
  wire [15:0] tx_crc;
  wire params_ok;
  wire busy;
  wire take_byte;
  wire crc_ok;
  wire id_ok;
  wire attach_ok;
  wire halt_ok;
  wire apb_access;
  wire apb_write;
  wire wake;
  wire addr_mapped;

  // running crc over every received byte of the frame
  crc_b_step u_rx_crc (
    .crc_in(crc_q),
    .data_in(rx_data),
    .crc_out(rx_crc_next)
  );

  // crc of the single response byte; transmitted inverted
  crc_b_step u_tx_crc (
    .crc_in(`CRC_INIT),
    .data_in(resp_q),
    .crc_out(tx_crc_raw)
  );
  assign tx_crc = ~tx_crc_raw;

  attach_param_check u_check (
    .param2(frame_q[6]),
    .param3(frame_q[7]),
    .param4(frame_q[8]),
    .ok(params_ok)
  );

  // receive side is deaf while an answer is still going out
  assign busy = (tx_st_q != TX_IDLE);
  assign take_byte = rx_valid && !busy;

  // frame evaluation in the rx_end cycle
  assign crc_ok = (crc_q == `CRC_RESIDUE);
  assign id_ok = ({frame_q[1], frame_q[2], frame_q[3], frame_q[4]} == pupi_q);
  assign attach_ok = enable_q && (state_q == `TAG_READY) && rx_end && !busy &&
                     (cnt_q == `LEN_ATTACH) && (frame_q[0] == `CMD_ATTACH) &&
                     crc_ok && id_ok && params_ok;
  assign halt_ok = enable_q && (state_q == `TAG_READY) && rx_end && !busy &&
                   (cnt_q == `LEN_HALT) && (frame_q[0] == `CMD_HALT) &&
                   crc_ok && id_ok;

  // apb decode; pready comes one cycle into the access phase
  assign apb_access = psel && penable && pready_q;
  assign apb_write = apb_access && pwrite;
  assign addr_mapped = (paddr == `REG_CTRL) || (paddr == `REG_PUPI) ||
                       (paddr == `REG_STATUS);
  assign wake = apb_write && (paddr == `REG_CTRL) && pwdata[`CTRL_WAKE_BIT];

  // apb slave: one wait state, unmapped addresses answer with pslverr
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_mapped;
      prdata_q <= 32'h0000_0000;
      if (psel && penable && !pready_q && !pwrite)
      begin
        case (paddr)
          `REG_CTRL: prdata_q <= {31'h0000_0000, enable_q};
          `REG_PUPI: prdata_q <= pupi_q;
          `REG_STATUS: prdata_q <= {8'h00, discard_q, 2'h0, rate_q, fsc_q,
                                    4'h0, halt_seen_q, attach_seen_q, state_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software settings: enable and the tag identifier
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q <= |(`CTRL_RESET & 32'h0000_0001);
      pupi_q <= PUPI_RESET;
    end
    else if (apb_write && (paddr == `REG_CTRL))
    begin
      enable_q <= pwdata[`CTRL_ENABLE_BIT];
    end
    else if (apb_write && (paddr == `REG_PUPI))
    begin
      pupi_q <= pwdata;
    end
  end

  // frame collector; bytes past the longest frame are not stored but still bump the crc, and the count until it stops at 15
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 4'h0;
      crc_q <= `CRC_INIT;
      for (k = 0; k < `FRAME_MAX; k = k + 1)
        frame_q[k] <= 8'h00;
    end
    else if (rx_end)
    begin
      cnt_q <= 4'h0;
      crc_q <= `CRC_INIT;
    end
    else if (take_byte)
    begin
      if (cnt_q < `LEN_ATTACH)
        frame_q[cnt_q] <= rx_data;
      if (cnt_q != 4'hF)
        cnt_q <= cnt_q + 4'h1;
      crc_q <= rx_crc_next;
    end
  end

  // tag state; software wake wins over a frame in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= `TAG_READY;
      app_enable_q <= 1'b0;
    end
    else if (wake)
    begin
      state_q <= `TAG_READY;
      app_enable_q <= 1'b0;
    end
    else if (attach_ok)
    begin
      state_q <= `TAG_ACTIVE;
      app_enable_q <= 1'b1;
    end
    else if (halt_ok)
    begin
      state_q <= `TAG_HALT;
      app_enable_q <= 1'b0;
    end
  end

  // sticky result flags and negotiated settings; set wins over clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      attach_seen_q <= 1'b0;
      halt_seen_q <= 1'b0;
      fsc_q <= 4'h0;
      rate_q <= 2'h0;
      discard_q <= 8'h00;
    end
    else
    begin
      attach_seen_q <= attach_ok || (attach_seen_q && !wake);
      halt_seen_q <= halt_ok || (halt_seen_q && !wake);
      if (attach_ok)
      begin
        fsc_q <= frame_q[6][3:0];
        rate_q <= frame_q[6][7:6];
      end
      // dropped frames are counted, saturating
      if (rx_end && !busy && !attach_ok && !halt_ok && (discard_q != 8'hFF))
        discard_q <= discard_q + 8'h01;
    end
  end

  // answer sequencer: code byte, crc low, crc high
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q <= TX_IDLE;
      resp_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
    end
    else
    begin
      case (tx_st_q)
        TX_IDLE:
        begin
          if (attach_ok)
          begin
            resp_q <= {`MAX_BUF_LEN_CODE, `CID_NONE};
            tx_data_q <= `RESP_ATTACH;
            tx_valid_q <= 1'b1;
            tx_st_q <= TX_CODE;
          end
          else if (halt_ok)
          begin
            resp_q <= `RESP_HALT;
            tx_data_q <= `RESP_HALT;
            tx_valid_q <= 1'b1;
            tx_st_q <= TX_CODE;
          end
        end
        TX_CODE:
        begin
          if (tx_ready)
          begin
            tx_data_q <= tx_crc[7:0];
            tx_st_q <= TX_CRC_LO;
          end
        end
        TX_CRC_LO:
        begin
          if (tx_ready)
          begin
            tx_data_q <= tx_crc[15:8];
            tx_last_q <= 1'b1;
            tx_st_q <= TX_CRC_HI;
          end
        end
        TX_CRC_HI:
        begin
          if (tx_ready)
          begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_st_q <= TX_IDLE;
          end
        end
        default:
        begin
          tx_st_q <= TX_IDLE;
          tx_valid_q <= 1'b0;
          tx_last_q <= 1'b0;
        end
      endcase
    end
  end

  // every output straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign tag_state = state_q;
  assign app_enable = app_enable_q;

endmodule // typeb_attach_halt_handler

`default_nettype wire

//--- tb/handler_properties.sv
// Purpose: port checks for the attach/halt handler
// Assumes: one clock, async active-low reset
// Notes: bound to every handler instance
`timescale 1ns/100ps
`default_nettype none
`include "typeb_defs.vh"
module handler_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic rx_end,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [1:0] tag_state,
  input wire logic app_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("slave error wrong");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_last}))
    else $error("answer byte dropped");
  a_attach_code: assert property (
    $rose(tx_valid) && tag_state == `TAG_ACTIVE |-> tx_data == 8'h10)
    else $error("attach answer code wrong");
  a_halt_code: assert property (
    $rose(tx_valid) && tag_state == `TAG_HALT |-> tx_data == 8'h00)
    else $error("halt answer code wrong");
  a_answer_cause: assert property ($rose(tx_valid) |-> $past(rx_end))
    else $error("answer without frame end");
  a_state_cause: assert property (
    $changed(tag_state) && tag_state != 2'h0 |-> $past(rx_end))
    else $error("state moved without frame");
  a_app_active: assert property (app_enable |-> tag_state == `TAG_ACTIVE)
    else $error("app enable outside active");
  a_last_ends: assert property (tx_valid && tx_last && tx_ready |=> !tx_valid)
    else $error("stream runs past last");
endmodule // handler_props
bind typeb_attach_halt_handler handler_props u_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .prdata, .rx_end, .tx_ready, .tx_valid, .tx_data, .tx_last,
  .tag_state, .app_enable);
`default_nettype wire

//--- tb/reader_model.sv
// Purpose: behavioural contactless reader facing the handler
// Assumes: bytes arrive decoded on pclk
// Notes: stall makes the reader a slow taker of answers
`timescale 1ns/100ps
`default_nettype none
module reader_model (
  input wire logic pclk,
  input wire logic stall,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  logic [7:0] got[$];
  logic got_last[$];
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end
  // reflected x.25 crc, inverted, as the reader appends it
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  // take answer bytes; random ready while stalling
  always @(posedge pclk)
  begin
    tx_ready <= stall ? 1'($urandom % 2) : 1'b1;
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      got_last.push_back(tx_last);
    end
  end
  // one frame, crc low byte first, end mark two cycles after the last byte
  task automatic send(input logic [7:0] f[$], input bit crc_ok);
    logic [15:0] c;
    c = crc(f) ^ {15'h0, !crc_ok};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~c[15:8]; // no stale byte on an idle line
    @(posedge pclk);
    rx_end <= 1'b1;
    @(posedge pclk);
    rx_end <= 1'b0;
  endtask
endmodule // reader_model
`default_nettype wire

//--- tb/typeb_attach_halt_handler_tb.sv
// Purpose: self-checking bench for the attach/halt handler
// Assumes: apb master and reader model drive on rising edges
// Notes: random parameter frames mixed with fixed corners
`timescale 1ns/100ps
`default_nettype none
`include "typeb_defs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module typeb_attach_halt_handler_tb;
  logic pclk, presetn, psel, penable, pwrite, stall, err;
  logic [7:0] paddr, p2, p3, p4;
  logic [31:0] pwdata, prdata, rd, pupi;
  logic pready, pslverr, rx_valid, rx_end, tx_ready, tx_valid, tx_last, app_enable;
  logic [7:0] rx_data, tx_data;
  logic [1:0] tag_state;
  int fails, total_checks, drops;
  typeb_attach_halt_handler DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_end, .tx_ready,
    .tx_valid, .tx_data, .tx_last, .tag_state, .app_enable);
  reader_model rdr (.pclk, .stall, .rx_valid, .rx_data, .rx_end, .tx_ready, .tx_valid,
    .tx_data, .tx_last);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hold the request until the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let an edge pass so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  function automatic bit good(input logic [7:0] a, b, c);
    return a[7:6] == a[5:4] && !a[7] && a[3:0] inside {[4'h5:4'h8]}
      && b == 8'h01 && c[3:0] == 4'h0;
  endfunction
  // send one frame and judge the answer; wake back to ready after success
  task automatic run(input logic [7:0] k, input logic [31:0] id, input bit ok, input bit ans);
    logic [7:0] f[$];
    logic [15:0] c;
    f = {k, id[31:24], id[23:16], id[15:8], id[7:0]};
    if (k == `CMD_ATTACH)
      f = {f, 8'($urandom), p2, p3, p4};
    rdr.got.delete();
    rdr.got_last.delete();
    drops += int'(!ans);
    rdr.send(f, ok);
    repeat (40) @(posedge pclk);
    f = {(k == `CMD_ATTACH) ? 8'h10 : 8'h00};
    c = rdr.crc(f);
    `CHK("answer length", ans ? 3 : 0, rdr.got.size())
    if (ans && rdr.got.size() == 3)
    begin
      `CHK("answer", {f[0], c}, {rdr.got[0], rdr.got[2], rdr.got[1]})
      `CHK("last flags", 3'b001, {rdr.got_last[0], rdr.got_last[1], rdr.got_last[2]})
    end
    `CHK("state", ans ? ((k == `CMD_ATTACH) ? 2'h1 : 2'h2) : 2'h0, tag_state)
    `CHK("app enable", ans && k == `CMD_ATTACH, app_enable)
    if (ans)
      apb(1'b1, `REG_CTRL, 32'h0000_0003);
  endtask
  initial
  begin
    void'($urandom(4));
    {psel, penable, pwrite, stall, paddr, pwdata, presetn} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0000_0001, rd)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("status reset", 32'h0, rd)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 33'h0_0000_0001, {rd, err})
    pupi = $urandom;
    apb(1'b1, `REG_PUPI, pupi);
    apb(1'b0, `REG_PUPI, 32'h0);
    `CHK("pupi", {pupi, 1'b0}, {rd, err})
    {p2, p3, p4} = {8'h08, 8'h01, 8'hF0};
    run(`CMD_ATTACH, pupi, 1, 1);
    {p2, p3, p4} = {8'h18, 8'h01, 8'h00};
    run(`CMD_ATTACH, pupi, 1, 0);
    {p2, p3, p4} = {8'h55, 8'h01, 8'h00};
    run(`CMD_ATTACH, pupi, 1, 1);
    run(`CMD_ATTACH, pupi, 0, 0);
    run(`CMD_ATTACH, pupi ^ 32'h1, 1, 0);
    run(`CMD_HALT, pupi ^ 32'h8000_0000, 1, 0);
    run(`CMD_HALT, pupi, 1, 1);
    repeat (36)
    begin
      p2 = 8'($urandom);
      if ($urandom % 4)
        p2 = {1'b0, p2[6], 1'b0, p2[6], 4'h5 + 4'($urandom % 4)};
      p3 = ($urandom % 2) ? 8'h01 : 8'($urandom);
      p4 = 8'($urandom);
      stall <= 1'($urandom);
      run(`CMD_ATTACH, pupi, 1, good(p2, p3, p4));
    end
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("drops", 8'(drops), rd[23:16])
    summarize();
  end
  initial
  begin
    #400000;
    fails++;
    summarize();
  end
endmodule // typeb_attach_halt_handler_tb
`default_nettype wire
